// [xcp_far.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// far-side receiver and open-collector wire
// ****************************************************************
module xcp_far (
  input  wire logic [4:0] frame_i,   // frame from generator
  input  wire logic [4:0] flip_i,    // bits the line corrupts
  input  wire logic [3:0] oe_i,      // pull-down enables
  output logic      [3:0] rx_data_o, // received word
  output logic            rx_par_o,  // received parity bit
  output logic      [3:0] wire_o     // resolved wired level
);
  // every data line plus parity reaches the checker, so a drop shows
  assign {rx_par_o, rx_data_o} = frame_i ^ flip_i;
  // pull-up wins unless a selector pulls the line low
  assign wire_o = ~oe_i;
endmodule // xcp_far
`default_nettype wire

// [xcp_parity.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// parity generator and checker, polarity fixed at elaboration
// ****************************************************************
module xcp_parity #(
  parameter int unsigned WIDTH = 4,   // data word width
  parameter bit          ODD   = 1'b0 // 1 selects odd parity
) (
  input  wire logic [WIDTH-1:0] data_i,   // word to protect
  input  wire logic [WIDTH-1:0] rx_data_i,// received word
  input  wire logic             rx_par_i, // received parity bit
  output logic                  gen_o,    // generated parity bit
  output logic                  chk_o     // 1 when frame is good
);
  logic even_gen; // xor tree result
  logic rx_ones;  // odd count over received frame

  // xor tree: 1 for odd count of ones
  assign even_gen = ^data_i;
  // odd generator only adds a final inversion
  assign gen_o    = ODD ? ~even_gen : even_gen;
  // checker sees every data line plus parity line
  assign rx_ones  = ^{rx_data_i, rx_par_i};
  assign chk_o    = ODD ? rx_ones : ~rx_ones;
endmodule // xcp_parity
`default_nettype wire

// [xcp_pkg.sv]
`default_nettype none
// ****************************************************************
// shared constants for the xor / compare / parity block
// ****************************************************************
package xcp_pkg;
  localparam int unsigned SEL_WIDTH  = 4;    // selector bit positions
  localparam int unsigned EQ4_WIDTH  = 4;    // small comparator width
  localparam int unsigned WIDE_MAX   = 32;   // wide comparator maximum
  localparam int unsigned WIDE_MIN   = 4;    // wide comparator minimum
  localparam int unsigned WIDE_LEN   = 32;   // wide comparator length in use
  localparam int unsigned BIG_WIDTH  = 128;  // wired-and comparator width
  localparam int unsigned PAR_WIDTH  = 4;    // parity data word width
  localparam int unsigned FRAME_BITS = PAR_WIDTH + 1;  // data plus parity
  localparam logic        OUT_RESET  = 1'b0; // reset value of result flops

  // select pair codes (high bit, low bit)
  typedef enum logic [1:0] {
    XCP_PASS_B   = 2'b00,
    XCP_INV_A    = 2'b01,
    XCP_PASS_B2  = 2'b10,
    XCP_FORCE_1  = 2'b11
  } xcp_sel_t;

  // per-bit difference: 1 when the inputs differ
  function automatic logic [BIG_WIDTH-1:0] xcp_diff(input logic [BIG_WIDTH-1:0] a,
                                                   input logic [BIG_WIDTH-1:0] b);
    xcp_diff = a ^ b;
  endfunction
endpackage
`default_nettype wire

// [xcp_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Operation
// - four selector bits each pick between two sources under two shared select lines.
// - select 00 or 10 gives the second source, 01 the inverted first source, 11 a one.
// - with both sources tied, the selector passes bits true or inverted as a complementor.
// - an open-collector copy of the selector output lets several selectors be wired together.
// - each exclusive-or gives 1 when its inputs differ and 0 when they match.
// - the 4-bit comparator nors the four difference bits, giving 1 only on a full match.
// - the wide comparator covers 4 to 32 bits and goes low on equal, high on unequal.
// - each equality gate gives 1 on equal bits and 0 on unequal bits.
// - the equality gates combine by a wired and, true only when all positions match.
// - the wired comparator spans two 128-bit words in one result.
// - the generator adds one parity bit to a 4-bit word and the checker reads all five bits.
// - the even generator gives 1 for an odd count of ones and 0 for an even count.
// - the odd generator is the even one with a final inversion.
// - the even checker gives 1 for an even count over data and parity, 0 otherwise.
// - the odd checker gives 1 for an odd count over data and parity, 0 otherwise.
module xcp_top #(
  parameter bit PARITY_ODD = 1'b0                   // 1 selects odd parity
) (
  input  wire logic                           CLK_I,         // 100 MHz clock
  input  wire logic                           RESET_N_I,     // async reset, active low
  input  wire logic [xcp_pkg::SEL_WIDTH-1:0]  SRC_A_I,       // first source word
  input  wire logic [xcp_pkg::SEL_WIDTH-1:0]  SRC_B_I,       // second source word
  input  wire logic                           SELECT_LOW_I,  // select line, low bit
  input  wire logic                           SELECT_HIGH_I, // select line, high bit
  output logic      [xcp_pkg::SEL_WIDTH-1:0]  SEL_O,         // selector result
  output logic      [xcp_pkg::SEL_WIDTH-1:0]  SEL_OC_O,      // open-collector level, always 0
  output logic      [xcp_pkg::SEL_WIDTH-1:0]  SEL_OC_OE_O,   // open-collector pull-down enable
  input  wire logic [xcp_pkg::BIG_WIDTH-1:0]  CMP_A_I,       // compare word a
  input  wire logic [xcp_pkg::BIG_WIDTH-1:0]  CMP_B_I,       // compare word b
  output logic      [xcp_pkg::EQ4_WIDTH-1:0]  DIFF4_O,       // per-bit differences, low 4 bits
  output logic                                EQ4_O,         // 1 when low 4 bits match
  output logic                                WIDE_NE_O,     // 0 when wide words match
  output logic      [xcp_pkg::BIG_WIDTH-1:0]  EQ_BITS_O,     // per-bit equality gates
  output logic                                EQ_ALL_O,      // 1 when all 128 bits match
  input  wire logic [xcp_pkg::PAR_WIDTH-1:0]  PAR_DATA_I,    // word to protect
  output logic      [xcp_pkg::FRAME_BITS-1:0] PAR_FRAME_O,   // word plus parity bit
  input  wire logic [xcp_pkg::PAR_WIDTH-1:0]  RX_DATA_I,     // received word
  input  wire logic                           RX_PAR_I,      // received parity bit
  output logic                                PAR_OK_O       // 1 when received frame is good
);
  // ****************************************************************
  // combinational datapath
  // ****************************************************************
  logic [xcp_pkg::SEL_WIDTH-1:0] next_sel;    // selector result
  logic [xcp_pkg::BIG_WIDTH-1:0] diff;        // per-bit differences
  logic [xcp_pkg::BIG_WIDTH-1:0] next_eqbits; // per-bit equality
  logic                          next_eq4;    // small compare
  logic                          next_wide_ne;// wide compare
  logic                          next_eqall;  // wired compare
  logic                          gen_bit;     // generated parity
  logic                          chk_bit;     // checker result
  xcp_pkg::xcp_sel_t             sel_code;    // shared select pair

  // select pair packed high bit first, matching the code table
  assign sel_code = xcp_pkg::xcp_sel_t'({SELECT_HIGH_I, SELECT_LOW_I});

  // one mux per bit; the select pair is shared by all positions
  genvar gi;
  generate
    for (gi = 0; gi < xcp_pkg::SEL_WIDTH; gi++) begin : g_sel
      always_comb begin
        case (sel_code)
          xcp_pkg::XCP_INV_A:   next_sel[gi] = ~SRC_A_I[gi];
          xcp_pkg::XCP_FORCE_1: next_sel[gi] = 1'b1;
          default:              next_sel[gi] = SRC_B_I[gi];
        endcase
      end
    end
  endgenerate

  // ****************************************************************
  // comparators
  // ****************************************************************
  // difference and equality gates over the full 128 bits; the narrower
  // comparators read slices, so all three agree on the shared low bits
  assign diff         = xcp_pkg::xcp_diff(CMP_A_I, CMP_B_I);
  assign next_eqbits  = ~diff;
  assign next_eq4     = ~|diff[xcp_pkg::EQ4_WIDTH-1:0];
  // nand of equalities: high on any mismatch within the wide length
  assign next_wide_ne = ~&next_eqbits[xcp_pkg::WIDE_LEN-1:0];
  // wired and of every equality gate
  assign next_eqall   = &next_eqbits;

  // ****************************************************************
  // parity
  // ****************************************************************
  // polarity chosen at elaboration; widths from shared constants
  xcp_parity #(
    .WIDTH (xcp_pkg::PAR_WIDTH),
    .ODD   (PARITY_ODD)
  ) u_parity (
    .data_i    (PAR_DATA_I),
    .rx_data_i (RX_DATA_I),
    .rx_par_i  (RX_PAR_I),
    .gen_o     (gen_bit),
    .chk_o     (chk_bit)
  );

  // ****************************************************************
  // result registers
  // ****************************************************************
  // selector and open-collector copy; out of reset, oc pulls low when result is 0
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SEL_O       <= '0;
      SEL_OC_OE_O <= '0;
    end else begin
      SEL_O       <= next_sel;
      SEL_OC_OE_O <= ~next_sel;
    end
  end

  // open collector never drives high, the pull-up does
  assign SEL_OC_O = '0;

  // comparator results
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      DIFF4_O   <= '0;
      EQ4_O     <= xcp_pkg::OUT_RESET;
      WIDE_NE_O <= xcp_pkg::OUT_RESET;
      EQ_BITS_O <= '0;
      EQ_ALL_O  <= xcp_pkg::OUT_RESET;
    end else begin
      DIFF4_O   <= diff[xcp_pkg::EQ4_WIDTH-1:0];
      EQ4_O     <= next_eq4;
      WIDE_NE_O <= next_wide_ne;
      EQ_BITS_O <= next_eqbits;
      EQ_ALL_O  <= next_eqall;
    end
  end

  // parity frame is data in the low bits, parity on top
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PAR_FRAME_O <= '0;
      PAR_OK_O    <= xcp_pkg::OUT_RESET;
    end else begin
      PAR_FRAME_O <= {gen_bit, PAR_DATA_I};
      PAR_OK_O    <= chk_bit;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // results carry a real answer only from the second edge after reset:
  // the first edge still shows reset values against inputs sampled in reset
  logic primed; // high once one result edge has passed
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // selector, each code against the sources held one edge earlier
  a_sel_force_one: assert property (primed && $past(SELECT_HIGH_I) && $past(SELECT_LOW_I)
                                    |-> SEL_O == 4'hf)
    else $error("select 11 did not force ones");
  a_sel_pass_b: assert property (primed && !$past(SELECT_LOW_I) |-> SEL_O == $past(SRC_B_I))
    else $error("selector did not pass second source");
  a_sel_code_two: assert property (primed && $past(SELECT_HIGH_I) && !$past(SELECT_LOW_I)
                                   |-> SEL_O == $past(SRC_B_I))
    else $error("select 10 did not pass second source");
  a_sel_invert_a: assert property (primed && !$past(SELECT_HIGH_I) && $past(SELECT_LOW_I)
                                   |-> SEL_O == ~$past(SRC_A_I))
    else $error("selector did not invert first source");
  // open collector never drives high; it pulls exactly where the result is 0
  a_oc_pulldown: assert property (primed |-> (SEL_OC_OE_O == ~SEL_O) && (SEL_OC_O == 4'h0))
    else $error("open collector enable mismatches result");

  // comparators, judged from the compared words where possible so that a
  // broken difference bus cannot hide behind a matching result
  a_diff_xor: assert property (primed |-> DIFF4_O == ($past(CMP_A_I[3:0]) ^ $past(CMP_B_I[3:0])))
    else $error("difference bits wrong");
  a_eq4_nor: assert property (primed |-> EQ4_O == (DIFF4_O == 4'h0))
    else $error("small compare disagrees with differences");
  a_eq4_words: assert property (primed |-> EQ4_O == ($past(CMP_A_I[3:0]) == $past(CMP_B_I[3:0])))
    else $error("small compare disagrees with words");
  a_wide_level: assert property (primed |->
                                 WIDE_NE_O == ($past(CMP_A_I[31:0]) != $past(CMP_B_I[31:0])))
    else $error("wide compare level wrong");
  a_wide_on_equal: assert property (primed && EQ_ALL_O |-> !WIDE_NE_O)
    else $error("wide compare high although all bits match");
  a_eq_gates: assert property (primed |-> EQ_BITS_O == ~($past(CMP_A_I) ^ $past(CMP_B_I)))
    else $error("equality gates wrong");
  a_wired_and: assert property (primed |-> (EQ_ALL_O == (&EQ_BITS_O)) && (!EQ_ALL_O || !WIDE_NE_O))
    else $error("wired and result wrong");
  a_eq_all_words: assert property (primed |-> EQ_ALL_O == ($past(CMP_A_I) == $past(CMP_B_I)))
    else $error("full width compare disagrees with words");

  // parity, polarity taken from the elaboration parameter
  a_frame_parity: assert property (primed |-> (^PAR_FRAME_O) == PARITY_ODD)
    else $error("generated frame has wrong parity");
  a_frame_data: assert property (primed |-> PAR_FRAME_O[3:0] == $past(PAR_DATA_I))
    else $error("frame data bits wrong");
  a_gen_bit: assert property (primed |-> PAR_FRAME_O[4] == ((^$past(PAR_DATA_I)) ^ PARITY_ODD))
    else $error("parity bit on top of frame wrong");
  // one flipped line on the far side must pull this low
  a_check_parity: assert property (primed |->
                                   PAR_OK_O == ((^{$past(RX_DATA_I), $past(RX_PAR_I)}) == PARITY_ODD))
    else $error("checker result wrong");

  // main scenarios
  c_sel_inverted: cover property (!SELECT_HIGH_I && SELECT_LOW_I ##1 SEL_O != 4'hf);
  c_sel_code_two: cover property (SELECT_HIGH_I && !SELECT_LOW_I ##1 SEL_O == $past(SRC_B_I));
  c_all_equal:    cover property (EQ_ALL_O);
  c_wide_differ:  cover property (WIDE_NE_O && EQ4_O);
  c_parity_bad:   cover property (!PAR_OK_O);
endmodule // xcp_top
`default_nettype wire

// [xor_compare_parity_mux_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module xor_compare_parity_mux_tb;
  logic         clk, rst_n, sl, sh, rx_par, ok, eq4, ne, eq_all, ok_odd, rx_par_odd;
  logic [3:0]   a, b, sel, oc, oe, diff4, rx_data, wl, pd, rx_data_odd;
  logic [4:0]   frame, flip, frame_odd;
  logic [127:0] ca, cb, eqb, d;
  int           err_count, total_checks, cyc;
  // ****************************************************************
  // design and far side
  // ****************************************************************
  xcp_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .SRC_A_I(a), .SRC_B_I(b), .SELECT_LOW_I(sl),
    .SELECT_HIGH_I(sh), .SEL_O(sel), .SEL_OC_O(oc), .SEL_OC_OE_O(oe), .CMP_A_I(ca), .CMP_B_I(cb),
    .DIFF4_O(diff4), .EQ4_O(eq4), .WIDE_NE_O(ne), .EQ_BITS_O(eqb), .EQ_ALL_O(eq_all),
    .PAR_DATA_I(pd), .PAR_FRAME_O(frame), .RX_DATA_I(rx_data), .RX_PAR_I(rx_par), .PAR_OK_O(ok));
  xcp_far far (.frame_i(frame), .flip_i(flip), .oe_i(oe), .rx_data_o(rx_data),
    .rx_par_o(rx_par), .wire_o(wl));
  // odd-polarity copy so the odd generator and checker are exercised too
  xcp_top #(.PARITY_ODD(1'b1)) dut_odd (.CLK_I(clk), .RESET_N_I(rst_n), .SRC_A_I(a), .SRC_B_I(b),
    .SELECT_LOW_I(sl), .SELECT_HIGH_I(sh), .SEL_O(), .SEL_OC_O(), .SEL_OC_OE_O(), .CMP_A_I(ca), .CMP_B_I(cb),
    .DIFF4_O(), .EQ4_O(), .WIDE_NE_O(), .EQ_BITS_O(), .EQ_ALL_O(), .PAR_DATA_I(pd), .PAR_FRAME_O(frame_odd),
    .RX_DATA_I(rx_data_odd), .RX_PAR_I(rx_par_odd), .PAR_OK_O(ok_odd));
  xcp_far far_odd (.frame_i(frame_odd), .flip_i(flip), .oe_i(oe), .rx_data_o(rx_data_odd),
    .rx_par_o(rx_par_odd), .wire_o());
  // clock and hang guard, sized well above the 75 or so cycles used
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every select code, last pass with both sources tied
  task automatic t_sel();
    logic [3:0] e;
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 3; v++) begin
        a = 4'h5 + 4'(v * 4);
        b = (v == 2) ? a : ~a;
        {sh, sl} = c[1:0];
        e = (c == 1) ? ~a : (c == 3) ? 4'hf : b;
        @(negedge clk);
        chk(sel, e, "selector");
        chk(wl, e, "wired level");
        chk(oc, 4'h0, "oc level");
      end
    end
    $display("test select done");
  endtask
  // single differing bit at each boundary of the three comparators
  task automatic t_cmp();
    int pos[8] = '{-1, 0, 3, 4, 31, 32, 64, 127};
    foreach (pos[i]) begin
      ca = {4{32'h9a3c_e107}} ^ 128'(i);
      cb = (pos[i] < 0) ? ca : ca ^ (128'h1 << pos[i]);
      d = ca ^ cb;
      @(negedge clk);
      chk(diff4, d[3:0], "diff4");
      chk(eq4, ~|d[3:0], "eq4");
      chk(ne, |d[31:0], "wide ne");
      chk(eqb, ~d, "eq bits");
      chk(eq_all, ~|d, "eq all");
    end
    $display("test compare done");
  endtask
  // all words, clean frame then one corrupted line
  task automatic t_par();
    for (int v = 0; v < 16; v++) begin
      pd = 4'(v);
      flip = 5'h0;
      @(negedge clk);
      chk(frame, {^pd, pd}, "frame");
      chk(frame_odd, {~^pd, pd}, "odd frame");
      @(negedge clk);
      chk(ok, 1'b1, "good frame");
      chk(ok_odd, 1'b1, "odd good frame");
      flip = 5'h1 << (v % 5);
      @(negedge clk);
      chk(ok, 1'b0, "dropped bit");
      chk(ok_odd, 1'b0, "odd dropped bit");
    end
    $display("test parity done");
  endtask
  // reset in mid-run clears at once, first edge after reloads
  task automatic t_rst();
    {sh, sl} = 2'b11;
    ca = '0;
    cb = '0;
    @(negedge clk);
    rst_n = 1'b0;
    #1;
    chk(sel, 4'h0, "sel in reset");
    chk(eq_all, 1'b0, "eq in reset");
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(sel, 4'hf, "sel after reset");
    chk(eq_all, 1'b1, "eq after reset");
    $display("test reset done");
  endtask
  initial begin
    {rst_n, sl, sh, a, b, pd, flip, ca, cb} = '0;
    repeat (4) @(negedge clk);
    chk(sel, 4'h0, "sel at start");
    rst_n = 1'b1;
    t_sel();
    t_cmp();
    t_par();
    t_rst();
    stop_test();
  end
endmodule // xor_compare_parity_mux_tb
`default_nettype wire
